// >>> hdl/qdw_pkg.sv
// Purpose: Shared constants for the quad converter two-wire write path
// Assumes: Both ends run on clk_sys (125 MHz); bus lines sampled synchronously
// Notes: Functional notes list below
//
// Functional notes
// - Master opens with address byte, write bit zero.
// - Control byte sets mode and channel.
// - Control bit zero picks power-down or data.
// - Data mode repeats high/low pairs until stop.
// - Power-down mode takes exactly two bytes.
// - Slave acknowledges address and control bytes.
// - Control byte field order fixed, ext addr first.
// - High byte bits 9..2, low byte 1..0.
// - Power-down bytes: two code bits, then zeros.
// - Master prefers repeated start over stop.
// - High-speed master code never acknowledged.
// - After master code, repeated start then address.
// - Address: fixed prefix, two pin bits, direction.
// - Update on acknowledge after low byte.
// - Channel select 00..11 picks A..D.
// - Load select: hold, load one, load all.
package qdw_pkg;
	// ----------------------------------------
	// Address and control layout
	// ----------------------------------------
	// Fixed prefix value arbitrary, not a real part code
	localparam logic [4:0] ADDR_PREFIX = 5'h15;
	localparam logic [3:0] HS_CODE_TOP = 4'h0;
	localparam int HS_CODE_BIT = 3;
	localparam int CTL_EXT3 = 7;
	localparam int CTL_EXT2 = 6;
	localparam int CTL_LOAD1 = 5;
	localparam int CTL_LOAD0 = 4;
	localparam int CTL_CH1 = 2;
	localparam int CTL_CH0 = 1;
	localparam int CTL_PDSEL = 0;
	localparam logic [1:0] LOAD_TEMP = 2'h0;
	localparam logic [1:0] LOAD_ONE = 2'h1;
	localparam logic [1:0] LOAD_ALL = 2'h2;
	localparam int NUM_CH = 4;
	localparam int DATA_W = 10;
	localparam int REG_W = 12;
	// ----------------------------------------
	// Timing: master bit phase length
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int QUARTER_NS = 320;
	localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;
endpackage : qdw_pkg

// >>> hdl/qdw_if.sv
// Purpose: Two-wire bus between master and slave write ends
// Assumes: Open-drain lines, pulled high when nobody drives
// Notes: Enables high while an end pulls its line low
`timescale 1ns/1ps
interface qdw_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_s;
	logic scl;
	logic sda;
	// Wired-and with pull-up
	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_s);
	modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
	modport slave (output sda_oe_s, input scl, input sda);
endinterface : qdw_if

// >>> hdl/qdw_slave.sv
// Purpose: Slave write receiver of the quad converter, four channels
// Assumes: scl and sda synchronous to clk_sys, slow against it
// Notes: Holding and output registers: two power-down bits over ten data bits
`timescale 1ns/1ps
module qdw_slave
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	// Bus
	qdw_if.slave bus,
	// Address pins
	input wire logic [1:0] addr_pins,
	input wire logic [1:0] ext_addr,
	// Channel state
	output logic [qdw_pkg::NUM_CH*qdw_pkg::REG_W-1:0] channel_holding_reg,
	output logic [qdw_pkg::NUM_CH*qdw_pkg::REG_W-1:0] channel_out_reg,
	output logic hs_mode
);
	import qdw_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CTRL, S_HI, S_LO, S_IGNORE} qdw_st_t;
	// ----------------------------------------
	// Edge and condition detect
	// ----------------------------------------
	// Line samples reset high like the idle bus, so no false edge
	logic scl_q, sda_q;
	wire scl_rise = bus.scl & ~scl_q;
	wire scl_fall = ~bus.scl & scl_q;
	wire start_c = bus.scl & scl_q & sda_q & ~bus.sda;
	wire stop_c = bus.scl & scl_q & ~sda_q & bus.sda;
	qdw_st_t st, next_st;
	logic [7:0] shreg, next_shreg;
	logic [3:0] bitc, next_bitc;
	logic ack_ph, next_ack_ph;
	logic ack_drv, next_ack_drv;
	logic [7:0] ctl, next_ctl;
	logic [7:0] hi, next_hi;
	logic upd, next_upd;
	logic hs, next_hs;
	logic first, next_first;
	logic [NUM_CH*REG_W-1:0] tr, next_tr, dr, next_dr;
	logic [REG_W-1:0] word;
	logic [1:0] ch;
	logic [1:0] ld;
	// ----------------------------------------
	// Receiver next state
	// ----------------------------------------
	// Next state of the receiver
	// Stop and start outrank bits: data never changes with clock high
	always_comb begin
		next_st = st;
		next_shreg = shreg;
		next_bitc = bitc;
		next_ack_ph = ack_ph;
		next_ack_drv = ack_drv;
		next_ctl = ctl;
		next_hi = hi;
		next_upd = 1'b0;
		next_hs = hs;
		next_first = first;
		if (stop_c) begin
			// Stop leaves high-speed timing too
			next_st = S_IDLE;
			next_ack_drv = 1'b0;
			next_hs = 1'b0;
		end else if (start_c) begin
			next_st = S_ADDR;
			next_bitc = 4'h0;
			next_ack_ph = 1'b0;
			next_ack_drv = 1'b0;
			next_first = 1'b1;
		end else if (st != S_IDLE) begin
			if (scl_rise && !ack_ph) begin
				next_shreg = {shreg[6:0], bus.sda};
				next_bitc = bitc + 4'h1;
			end
			if (scl_fall && !ack_ph && bitc == 4'h8) begin
				next_ack_ph = 1'b1;
				next_bitc = 4'h0;
				unique case (st)
					S_ADDR: begin
						if (first && shreg[7:4] == HS_CODE_TOP && shreg[HS_CODE_BIT]) begin
							// master code, no acknowledge
							// Cleared only by stop: repeated start stays fast
							next_hs = 1'b1;
							next_st = S_IGNORE;
						end else if (shreg[7:3] == ADDR_PREFIX && shreg[2:1] == addr_pins
								&& !shreg[0]) begin
							next_ack_drv = 1'b1;
							next_st = S_CTRL;
						end else begin
							next_st = S_IGNORE;
						end
						next_first = 1'b0;
					end
					S_CTRL: begin
						next_ctl = shreg;
						if (shreg[CTL_EXT3:CTL_EXT2] == ext_addr) begin
							next_ack_drv = 1'b1;
							next_st = S_HI;
						end else begin
							next_st = S_IGNORE;
						end
					end
					S_HI: begin
						next_hi = shreg;
						next_ack_drv = 1'b1;
						next_st = S_LO;
					end
					S_LO: begin
						next_ack_drv = 1'b1;
						// update at acknowledge start
						// Pair is complete here, master still holds clock low
						next_upd = 1'b1;
						next_st = ctl[CTL_PDSEL] ? S_IGNORE : S_HI;
					end
					default: next_st = S_IGNORE;
				endcase
			end else if (scl_fall && ack_ph) begin
				next_ack_ph = 1'b0;
				next_ack_drv = 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Word assembly and channel update
	// ----------------------------------------
	// Assemble the word from the latched pair
	// Power-down keeps the data bits of the output register
	always_comb begin
		ch = ctl[CTL_CH1:CTL_CH0];
		ld = ctl[CTL_LOAD1:CTL_LOAD0];
		if (ctl[CTL_PDSEL])
			word = {hi[7:6], dr[ch*REG_W +: DATA_W]};
		else
			word = {dr[ch*REG_W+DATA_W +: 2], hi, shreg[7:6]};
		next_tr = tr;
		next_dr = dr;
		if (upd) begin
			next_tr[ch*REG_W +: REG_W] = word;
			if (ld == LOAD_ONE)
				next_dr[ch*REG_W +: REG_W] = word;
			else if (ld == LOAD_ALL)
				next_dr = next_tr;
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Receiver registers, frozen while clk_en low
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			st <= S_IDLE;
			shreg <= 8'h00;
			bitc <= 4'h0;
			ack_ph <= 1'b0;
			ack_drv <= 1'b0;
			ctl <= 8'h00;
			hi <= 8'h00;
			upd <= 1'b0;
			hs <= 1'b0;
			first <= 1'b0;
		end else if (clk_en) begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
			st <= next_st;
			shreg <= next_shreg;
			bitc <= next_bitc;
			ack_ph <= next_ack_ph;
			ack_drv <= next_ack_drv;
			ctl <= next_ctl;
			hi <= next_hi;
			upd <= next_upd;
			hs <= next_hs;
			first <= next_first;
		end
	end
	// Channel registers, apart so they only move on an update
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tr <= '0;
			dr <= '0;
		end else if (clk_en) begin
			tr <= next_tr;
			dr <= next_dr;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Outputs from flops, no logic after them
	assign bus.sda_oe_s = ack_drv;
	assign channel_holding_reg = tr;
	assign channel_out_reg = dr;
	assign hs_mode = hs;
endmodule : qdw_slave

// >>> hdl/qdw_master.sv
// Purpose: Bus master that writes one word to the quad converter
// Assumes: Single master on the bus
// Notes: One quarter-bit counter paces every phase
`timescale 1ns/1ps
module qdw_master
#(
	parameter int QUARTER = qdw_pkg::QUARTER_CYC
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	// Bus
	qdw_if.master bus,
	// Request
	input wire logic req,
	input wire logic [1:0] addr_pins,
	input wire logic [7:0] ctrl_byte,
	input wire logic [7:0] hi_byte,
	input wire logic [7:0] lo_byte,
	input wire logic use_hs,
	output logic busy,
	output logic done,
	output logic nack
);
	import qdw_pkg::*;
	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} qdw_mst_t;
	// ----------------------------------------
	// Byte sequencer
	// ----------------------------------------
	qdw_mst_t st, next_st;
	logic [15:0] tick, next_tick;
	logic [1:0] ph, next_ph;
	logic [3:0] bitc, next_bitc;
	logic [2:0] idx, next_idx;
	logic [39:0] bytes, next_bytes;
	logic scl_d, next_scl_d, sda_d, next_sda_d;
	logic bsy, next_bsy, dn, next_dn, nk, next_nk;
	logic hs_pend, next_hs_pend;
	wire tick_end = (tick == 16'(QUARTER - 1));
	always_comb begin
		next_st = st;
		next_tick = tick_end ? 16'h0000 : tick + 16'h0001;
		next_ph = ph;
		next_bitc = bitc;
		next_idx = idx;
		next_bytes = bytes;
		next_scl_d = scl_d;
		next_sda_d = sda_d;
		next_bsy = bsy;
		next_dn = 1'b0;
		next_nk = nk;
		next_hs_pend = hs_pend;
		unique case (st)
			M_IDLE: begin
				next_tick = 16'h0000;
				if (req) begin
					next_bytes = {ADDR_PREFIX, addr_pins, 1'b0, ctrl_byte, hi_byte, lo_byte, 8'h00};
					if (use_hs)
						next_bytes = {HS_CODE_TOP, 4'h8, ADDR_PREFIX, addr_pins, 1'b0,
							ctrl_byte, hi_byte, lo_byte};
					next_hs_pend = use_hs;
					next_idx = 3'h0;
					next_nk = 1'b0;
					next_bsy = 1'b1;
					next_ph = 2'h0;
					next_st = M_START;
				end
			end
			M_START: if (tick_end) begin
				next_ph = ph + 2'h1;
				// Release both, pull data, pull clock
				if (ph == 2'h0) begin
					next_scl_d = 1'b0;
					next_sda_d = 1'b0;
				end else if (ph == 2'h1)
					next_sda_d = 1'b1;
				else if (ph == 2'h2)
					next_scl_d = 1'b1;
				else begin
					next_bitc = 4'h0;
					next_st = M_BIT;
				end
			end
			M_BIT: if (tick_end) begin
				next_ph = ph + 2'h1;
				unique case (ph)
					2'h0: next_sda_d = (bitc == 4'h8) ? 1'b0 : ~bytes[39];
					2'h1: next_scl_d = 1'b0;
					2'h2: if (bitc == 4'h8 && bus.sda && !(hs_pend && idx == 3'h0))
						next_nk = 1'b1;
					default: begin
						next_scl_d = 1'b1;
						if (bitc == 4'h8) begin
							next_bitc = 4'h0;
							next_idx = idx + 3'h1;
							if (hs_pend && idx == 3'h0) begin
								// repeated start then address
								// Byte count restarts at the address byte
								next_hs_pend = 1'b0;
								next_idx = 3'h0;
								next_ph = 2'h0;
								next_st = M_START;
							end else if (nk || idx == 3'h3)
								next_st = M_STOP;
						end else begin
							next_bitc = bitc + 4'h1;
							next_bytes = {bytes[38:0], 1'b0};
						end
					end
				endcase
			end
			M_STOP: if (tick_end) begin
				next_ph = ph + 2'h1;
				// stop used to hand bus back
				if (ph == 2'h0)
					next_sda_d = 1'b1;
				else if (ph == 2'h1)
					next_scl_d = 1'b0;
				else if (ph == 2'h2)
					next_sda_d = 1'b0;
				else begin
					next_bsy = 1'b0;
					next_dn = 1'b1;
					next_st = M_IDLE;
				end
			end
		endcase
	end
	// Registers, frozen while clk_en low
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st <= M_IDLE;
			tick <= 16'h0000;
			ph <= 2'h0;
			bitc <= 4'h0;
			idx <= 3'h0;
			bytes <= '0;
			scl_d <= 1'b0;
			sda_d <= 1'b0;
			bsy <= 1'b0;
			dn <= 1'b0;
			nk <= 1'b0;
			hs_pend <= 1'b0;
		end else if (clk_en) begin
			st <= next_st;
			tick <= next_tick;
			ph <= next_ph;
			bitc <= next_bitc;
			idx <= next_idx;
			bytes <= next_bytes;
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
			bsy <= next_bsy;
			dn <= next_dn;
			nk <= next_nk;
			hs_pend <= next_hs_pend;
		end
	end
	assign bus.scl_oe_m = scl_d;
	assign bus.sda_oe_m = sda_d;
	assign busy = bsy;
	assign done = dn;
	assign nack = nk;
endmodule : qdw_master

// >>> test/qdw_monitor.sv
// Purpose: Bus checker beside the two-wire link
// Assumes: Lines sampled on clk_sys, slow against it
// Notes: pins must follow the slave address pins
`timescale 1ns/1ps
module qdw_monitor
	import qdw_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Slave address pins
	input wire logic [1:0] pins,
	// Bus
	input wire logic scl_oe_m,
	input wire logic sda_oe_m,
	input wire logic sda_oe_s,
	input wire logic scl,
	input wire logic sda
);
	// ----------------------------------------
	// Bit and byte tracking
	// ----------------------------------------
	logic ps, pc, rise, start, stop;
	logic [3:0] bc;
	logic [7:0] sh;
	logic [2:0] nb;
	assign rise = scl && !pc;
	assign start = scl && pc && ps && !sda;
	assign stop = scl && pc && !ps && sda;
	// Count bits from each start, ninth is ack
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ps <= 1'b1;
			pc <= 1'b1;
			bc <= 4'h0;
			sh <= 8'h00;
			nb <= 3'h0;
		end else begin
			ps <= sda;
			pc <= scl;
			if (start) begin
				bc <= 4'h0;
				nb <= 3'h0;
			end else if (rise && bc == 4'h8) begin
				bc <= 4'h0;
				nb <= (nb == 3'h7) ? nb : nb + 3'h1;
			end else if (rise) begin
				bc <= bc + 4'h1;
				sh <= {sh[6:0], sda};
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_ack_slot;
		$rose(sda_oe_s) |-> bc == 4'h8 && !scl;
	endproperty
	a_ack_slot: assert property (p_ack_slot) else $error("ack outside ack slot");
	property p_ack_hold;
		scl && $past(scl) && $past(sda_oe_s) |-> sda_oe_s;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped with clock high");
	property p_ack_len;
		$rose(sda_oe_s) |-> sda_oe_s [*6] ##[1:4] !sda_oe_s;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
	property p_code_nack;
		rise && bc == 4'h8 && nb == 3'h0 && sh[7:3] == 5'h01 |-> sda;
	endproperty
	a_code_nack: assert property (p_code_nack) else $error("master code acked");
	property p_prefix_nack;
		rise && bc == 4'h8 && nb == 3'h0 && sh[7:1] != {ADDR_PREFIX, pins} && sh[7:3] != 5'h01
			|-> sda;
	endproperty
	a_prefix_nack: assert property (p_prefix_nack) else $error("foreign address acked");
	property p_addr_ack;
		rise && bc == 4'h8 && nb == 3'h0 && sh == {ADDR_PREFIX, pins, 1'b0} |-> !sda;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
	property p_stop_quiet;
		stop |=> !sda_oe_s [*8];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("slave drives after stop");
	property p_ack_release;
		sda_oe_s && bc == 4'h0 |-> ##[1:6] !sda_oe_s;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack not released");
	// Main scenarios reached
	c_ack: cover property ($rose(sda_oe_s));
	c_code: cover property (rise && bc == 4'h8 && nb == 3'h0 && sh[7:3] == 5'h01);
	c_stop: cover property (stop);
endmodule : qdw_monitor

// >>> test/qdw_tb.sv
// Purpose: Master and slave ends joined, writes checked
// Assumes: Data writes keep the output power-down bits
// Notes: QUARTER shortened to 2 to keep the run short
`timescale 1ns/1ps
module qdw_tb;
	import qdw_pkg::*;
	logic clk_sys = 0, resetn = 0, req = 0, use_hs = 0, hs, busy, done, nack;
	logic [1:0] pins = 0, ext = 0, spins = 0;
	logic [7:0] cb = 0, hb = 0, lb = 0;
	logic [47:0] hold, outr, mh = 0, mo = 0;
	logic [47:0] q_h[$], q_o[$];
	logic q_n[$];
	int bad_count = 0, comparisons = 0;
	qdw_if bus();
	// Clock, 8 ns
	always #4 clk_sys = ~clk_sys;
	qdw_master #(.QUARTER(2)) qdw_master_inst(.clk_sys(clk_sys), .resetn(resetn),
		.clk_en(1'b1), .bus(bus.master), .req(req), .addr_pins(pins), .ctrl_byte(cb),
		.hi_byte(hb), .lo_byte(lb), .use_hs(use_hs), .busy(busy), .done(done), .nack(nack));
	qdw_slave qdw_slave_inst(.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
		.bus(bus.slave), .addr_pins(spins), .ext_addr(ext), .channel_holding_reg(hold),
		.channel_out_reg(outr), .hs_mode(hs));
	qdw_monitor qdw_monitor_inst(.clk_sys(clk_sys), .resetn(resetn), .pins(spins),
		.scl_oe_m(bus.scl_oe_m), .sda_oe_m(bus.sda_oe_m), .sda_oe_s(bus.sda_oe_s),
		.scl(bus.scl), .sda(bus.sda));
	// ----------------------------------------
	// Compare and close
	// ----------------------------------------
	task cmp48(input logic [47:0] e, input logic [47:0] a);
		comparisons++;
		if (a !== e) begin
			bad_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : cmp48
	task cmp1(input logic e, input logic a);
		comparisons++;
		if (a !== e) begin
			bad_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : cmp1
	task close_out;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// One write, model updated first
	// ----------------------------------------
	task wr(input logic [1:0] p, input logic [1:0] x, input logic [1:0] ld,
		input logic [1:0] ch, input logic pd, input logic hsm);
		logic [7:0] h, l;
		int i;
		logic seen;
		seen = 1'b0;
		h = 8'($urandom);
		l = 8'($urandom);
		if (pd) begin
			h[5:0] = 6'h00;
			l[7:6] = 2'h0;
		end
		if (p == spins && x == ext) begin
			i = 12 * ch;
			if (pd) mh[i+:12] = {h[7:6], mo[i+:10]};
			else mh[i+:12] = {mo[i+10+:2], h, l[7:6]};
			if (ld == LOAD_ONE) mo[i+:12] = mh[i+:12];
			if (ld == LOAD_ALL) mo = mh;
		end
		q_h.push_back(mh);
		q_o.push_back(mo);
		q_n.push_back(!(p == spins && x == ext));
		@(negedge clk_sys);
		pins = p;
		cb = {x, ld, 1'($urandom), ch, pd};
		hb = h;
		lb = l;
		use_hs = hsm;
		req = 1;
		for (i = 0; i < 50 && busy !== 1'b1; i++) @(negedge clk_sys);
		if (busy !== 1'b1) bad_count++;
		req = 0;
		for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(negedge clk_sys);
			seen = seen | hs;
		end
		if (busy !== 1'b0) bad_count++;
		cmp1(hsm, seen);
		repeat (2) @(negedge clk_sys);
		cmp1(1'b0, hs);
	endtask : wr
	// Result watcher, oldest note first, away from the launching edge
	always @(negedge clk_sys) begin
		if (done === 1'b1) begin
			cmp48(q_h.pop_front(), hold);
			cmp48(q_o.pop_front(), outr);
			cmp1(q_n.pop_front(), nack);
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'ha5f8e543));
		ext = 2'($urandom);
		spins = 2'($urandom);
		repeat (4) @(negedge clk_sys);
		resetn = 1;
		for (int l = 0; l < 3; l++) begin
			for (int c = 0; c < 4; c++) begin
				wr(spins, ext, 2'(l), 2'(c), 1'($urandom), 1'b0);
			end
		end
		$display("test loads done");
		wr(spins, ext, LOAD_ONE, 2'h2, 1'b1, 1'b0);
		wr(spins ^ 2'h1, ext, LOAD_ONE, 2'h0, 1'b0, 1'b0);
		wr(spins, ~ext, LOAD_ALL, 2'h1, 1'b0, 1'b0);
		$display("test refusals done");
		wr(spins, ext, LOAD_ALL, 2'h3, 1'b0, 1'b1);
		$display("test high speed done");
		close_out();
	end
	// Watchdog, far beyond sixteen writes
	initial begin
		#500000;
		bad_count++;
		close_out();
	end
endmodule : qdw_tb
